// ### common/iprc_defs.vh
// Constants for the comparator and converter-pair priority register block.
// Assumes a classic Wishbone slave with 32-bit data; each register takes one aligned word.
`ifndef IPRC_DEFS_VH
`define IPRC_DEFS_VH

`define IPRC_ADDR_CMP_A      4'h0
`define IPRC_ADDR_CMP_B      4'h4
`define IPRC_ADDR_PAIR_LOW   4'h8
`define IPRC_ADDR_PAIR_HIGH  4'hC

`define IPRC_MASK_CMP_A      16'h7770
`define IPRC_MASK_CMP_B      16'h0007
`define IPRC_MASK_PAIR_LOW   16'h7770
`define IPRC_MASK_PAIR_HIGH  16'h0777

`define IPRC_RST_CMP_A       16'h4440
`define IPRC_RST_CMP_B       16'h0004
`define IPRC_RST_PAIR_LOW    16'h4440
`define IPRC_RST_PAIR_HIGH   16'h0444

`define IPRC_LEVEL_OFF       3'h0
`define IPRC_LEVEL_MAX       3'h7

`endif

// ### verilog/iprc_reg16.v
// One 16-bit priority register with a fixed implemented-bit mask.
// Assumes the write strobe and byte enables are already decoded by the bus slave.
`include "iprc_defs.vh"

module iprc_reg16 #(
  parameter [15:0] MASK      = 16'hFFFF,
  parameter [15:0] RST_VALUE = 16'h0000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Write side
  input  wire        wr_en,
  input  wire [1:0]  byte_en,
  input  wire [15:0] wr_data,
  // Stored value
  output wire [15:0] value
);

  reg  [15:0] value_q;
  reg  [15:0] value_d;
  wire [15:0] lane_mask;

  assign lane_mask = {{8{byte_en[1]}}, {8{byte_en[0]}}} & MASK;

  always @* begin
    value_d = value_q;
    if (wr_en) begin
      value_d = (value_q & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      value_q <= RST_VALUE & MASK;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q & MASK;

endmodule

// ### verilog/iprc_top.v
// Priority registers for four comparator sources and six converter-pair sources.
// Assumes a classic Wishbone master on the same clock; the levels feed an arbiter elsewhere.
`include "iprc_defs.vh"

module iprc_top (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Priority levels to the arbiter
  output wire [2:0]  cmp1_level,
  output wire [2:0]  cmp2_level,
  output wire [2:0]  cmp3_level,
  output wire [2:0]  cmp4_level,
  output wire [2:0]  conv_pair0_level,
  output wire [2:0]  conv_pair1_level,
  output wire [2:0]  conv_pair2_level,
  output wire [2:0]  conv_pair3_level,
  output wire [2:0]  conv_pair4_level,
  output wire [2:0]  conv_pair5_level,
  // Source enables, low when the level is zero
  output wire [3:0]  cmp_enabled,
  output wire [5:0]  conv_pair_enabled
);

  // A level of zero disables the source; 1..7 is the level itself, 7 highest.
  function src_on;
    input [2:0] level;
    begin
      src_on = (level != `IPRC_LEVEL_OFF);
    end
  endfunction

  wire        req;
  wire [3:0]  sel_reg;
  wire        mapped;
  wire [15:0] val_cmp_a;
  wire [15:0] val_cmp_b;
  wire [15:0] val_pair_low;
  wire [15:0] val_pair_high;
  reg  [15:0] rd_mux;

  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign sel_reg[0] = (wb_adr_i == `IPRC_ADDR_CMP_A);
  assign sel_reg[1] = (wb_adr_i == `IPRC_ADDR_CMP_B);
  assign sel_reg[2] = (wb_adr_i == `IPRC_ADDR_PAIR_LOW);
  assign sel_reg[3] = (wb_adr_i == `IPRC_ADDR_PAIR_HIGH);
  assign mapped     = |sel_reg;

  iprc_reg16 #(
    .MASK      (`IPRC_MASK_CMP_A),
    .RST_VALUE (`IPRC_RST_CMP_A)
  ) u_cmp_a (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (req & wb_we_i & sel_reg[0]),
    .byte_en (wb_sel_i[1:0]),
    .wr_data (wb_dat_i[15:0]),
    .value   (val_cmp_a)
  );

  iprc_reg16 #(
    .MASK      (`IPRC_MASK_CMP_B),
    .RST_VALUE (`IPRC_RST_CMP_B)
  ) u_cmp_b (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (req & wb_we_i & sel_reg[1]),
    .byte_en (wb_sel_i[1:0]),
    .wr_data (wb_dat_i[15:0]),
    .value   (val_cmp_b)
  );

  iprc_reg16 #(
    .MASK      (`IPRC_MASK_PAIR_LOW),
    .RST_VALUE (`IPRC_RST_PAIR_LOW)
  ) u_pair_low (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (req & wb_we_i & sel_reg[2]),
    .byte_en (wb_sel_i[1:0]),
    .wr_data (wb_dat_i[15:0]),
    .value   (val_pair_low)
  );

  iprc_reg16 #(
    .MASK      (`IPRC_MASK_PAIR_HIGH),
    .RST_VALUE (`IPRC_RST_PAIR_HIGH)
  ) u_pair_high (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (req & wb_we_i & sel_reg[3]),
    .byte_en (wb_sel_i[1:0]),
    .wr_data (wb_dat_i[15:0]),
    .value   (val_pair_high)
  );

  always @* begin
    case (wb_adr_i)
      `IPRC_ADDR_CMP_A:     rd_mux = val_cmp_a;
      `IPRC_ADDR_CMP_B:     rd_mux = val_cmp_b;
      `IPRC_ADDR_PAIR_LOW:  rd_mux = val_pair_low;
      `IPRC_ADDR_PAIR_HIGH: rd_mux = val_pair_high;
      default:              rd_mux = 16'h0000;
    endcase
  end

  // Each request is answered one cycle later; an unmapped address gets err instead of ack.
  always @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      if (req & ~wb_we_i) begin
        wb_dat_o <= {16'h0000, rd_mux};
      end
    end
  end

  assign cmp3_level       = val_cmp_a[14:12];
  assign cmp2_level       = val_cmp_a[10:8];
  assign cmp1_level       = val_cmp_a[6:4];
  assign cmp4_level       = val_cmp_b[2:0];
  assign conv_pair2_level = val_pair_low[14:12];
  assign conv_pair1_level = val_pair_low[10:8];
  assign conv_pair0_level = val_pair_low[6:4];
  assign conv_pair5_level = val_pair_high[10:8];
  assign conv_pair4_level = val_pair_high[6:4];
  assign conv_pair3_level = val_pair_high[2:0];

  // The level outputs carry the stored code unchanged: 111 is 7, 001 is 1.
  assign cmp_enabled = {src_on(cmp4_level), src_on(cmp3_level),
                        src_on(cmp2_level), src_on(cmp1_level)};
  assign conv_pair_enabled = {src_on(conv_pair5_level), src_on(conv_pair4_level),
                              src_on(conv_pair3_level), src_on(conv_pair2_level),
                              src_on(conv_pair1_level), src_on(conv_pair0_level)};

endmodule

// ### sim/iprc_top_properties.sv
// Checker for the priority register block.
// Assumes it is bound to iprc_top and sees only its ports.
module iprc_chk (
  input wire logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
  input wire logic [3:0]  wb_adr_i, wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [2:0]  cmp1_level, cmp4_level, conv_pair3_level,
  input wire logic [3:0]  cmp_enabled,
  input wire logic [5:0]  conv_pair_enabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire tk = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
  resp_once_a: assert property (tk |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered once");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  no_stray_a: assert property (wb_ack_o | wb_err_o |-> $past(tk))
    else $error("answer without request");
  cmp4_write_a: assert property (tk && wb_we_i && wb_adr_i == 4'h4 && wb_sel_i[0]
    |=> cmp4_level == $past(wb_dat_i[2:0])) else $error("cmp4 level not written");
  cmp4_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h4
    |-> wb_dat_o == {29'h0, cmp4_level}) else $error("cmp4 readback wrong");
  cmp1_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h0
    |-> (wb_dat_o & ~32'h7770) == 0 && wb_dat_o[6:4] == cmp1_level) else $error("cmp1 read");
  cmp1_hold_a: assert property (!(tk && wb_we_i) |=> $stable(cmp1_level))
    else $error("level changed without write");
  enable_map_a: assert property (cmp_enabled[3] == (cmp4_level != 0)
    && conv_pair_enabled[3] == (conv_pair3_level != 0)) else $error("enable wrong");
  cover property (tk && wb_we_i);
  cover property (tk && !wb_we_i);
  cover property (wb_err_o);
endmodule

bind iprc_top iprc_chk u_chk (.*);

// ### sim/tb_iprc_top.sv
// Self-checking bench for the priority register block.
// Assumes one Wishbone answer per request taken.
module tb_iprc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, err;
  logic [3:0]  adr = 0, sel = 0, ce;
  logic [5:0]  pe;
  logic [31:0] di = 0, dout, st = 32'h9886, r;
  logic [29:0] lv, x;
  logic [9:0]  en;
  logic [17:0] e;
  logic [15:0] m [4];
  logic [17:0] q [$];
  int          mismatches = 0, samples_checked = 0, cyc_n = 0;
  localparam logic [63:0] MK = {16'h0777, 16'h7770, 16'h0007, 16'h7770};
  localparam logic [63:0] RS = {16'h0444, 16'h4440, 16'h0004, 16'h4440};
  always #50 clk = ~clk;
  iprc_top u_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack),
    .wb_err_o(err), .cmp1_level(lv[2:0]), .cmp2_level(lv[5:3]), .cmp3_level(lv[8:6]),
    .cmp4_level(lv[11:9]), .conv_pair0_level(lv[14:12]), .conv_pair1_level(lv[17:15]),
    .conv_pair2_level(lv[20:18]), .conv_pair3_level(lv[23:21]),
    .conv_pair4_level(lv[26:24]), .conv_pair5_level(lv[29:27]),
    .cmp_enabled(ce), .conv_pair_enabled(pe));
  function logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] x0);
    samples_checked++;
    if (s !== x0) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x0);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int i;
    i = a[3:2];
    @(posedge clk);
    {cyc, stb, we, adr, sel, di} <= {2'b11, w, a, s, d};
    q.push_back({~w, a[1:0] != 0, (a[1:0] != 0) ? 16'h0 : m[i]});
    do @(posedge clk); while (!(ack | err));
    {cyc, stb} <= 2'b00;
    if (w && a[1:0] == 0) begin
      if (s[0]) m[i][7:0] = d[7:0] & MK[16*i+:8];
      if (s[1]) m[i][15:8] = d[15:8] & MK[16*i+8+:8];
    end
  endtask
  task rst();
    reset <= 1;
    repeat (8) @(posedge clk);
    reset <= 0;
    for (int i = 0; i < 4; i++) m[i] = RS[16*i+:16];
  endtask
  task lvchk();
    x = {m[3][10:8], m[3][6:4], m[3][2:0], m[2][14:12], m[2][10:8], m[2][6:4],
      m[1][2:0], m[0][14:12], m[0][10:8], m[0][6:4]};
    for (int k = 0; k < 10; k++) en[k] = x[3*k+:3] != 0;
    chk({2'b0, lv}, {2'b0, x});
    chk({22'h0, pe, ce}, {22'h0, en});
  endtask
  always @(posedge clk) begin
    if (ack | err) begin
      e = q.pop_front();
      chk({31'h0, err}, {31'h0, e[16]});
      if (e[17]) chk(dout, {16'h0, e[15:0]});
    end
    if (++cyc_n == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    rst();
    lvchk();
    for (int i = 0; i < 4; i++) wb(0, 4'(i * 4), 4'hF, 0);
    $display("test reset done");
    for (int v = 0; v < 8; v++) begin
      for (int i = 0; i < 4; i++) wb(1, 4'(i * 4), 4'h3, {8{4'(v)}});
      lvchk();
    end
    $display("test codes done");
    repeat (60) begin
      r = xs();
      wb(1, r[3:0], r[7:4], r);
      lvchk();
      wb(0, r[3:0], 4'hF, 0);
    end
    $display("test random done");
    rst();
    lvchk();
    wb(0, 4'hC, 4'hF, 0);
    $display("test rereset done");
    @(posedge clk);
    end_sim();
  end
endmodule
